// file: include/spcp_map.svh
// Offsets, field positions, table codes and timing counts of the status poller cable port
`ifndef SPCP_MAP_SVH
`define SPCP_MAP_SVH
`define SPCP_ADDR_W 4
`define SPCP_OFF_CTRL 4'h0
`define SPCP_OFF_STATUS 4'h1
`define SPCP_OFF_TX_BYTE 4'h2
`define SPCP_OFF_RX_BYTE 4'h3
`define SPCP_OFF_TBL_ADDR 4'h4
`define SPCP_OFF_TBL_DATA 4'h5
`define SPCP_OFF_NOTE_USER 4'h6
`define SPCP_OFF_NOTE_STAT 4'h7
`define SPCP_OFF_SRQ 4'h8
`define SPCP_CTRL_GO 0
`define SPCP_CTRL_INIT 1
`define SPCP_ST_TXREQ 0
`define SPCP_ST_RXRDY 1
`define SPCP_ST_PHASE 2
`define SPCP_ST_INITDONE 3
`define SPCP_ST_NOTE 4
`define SPCP_UNASSIGNED_BIT 15
`define SPCP_TERM_WORD 16'hffff
`define SPCP_OOS_ALL 8'hff
`define SPCP_BYTE_US 480
`define SPCP_CLK_MHZ 200
`define SPCP_BYTE_CYC (`SPCP_BYTE_US * `SPCP_CLK_MHZ)
`define SPCP_FLAG_PULSES 256
`define SPCP_TX_BYTES 6
`define SPCP_RX_BYTES 4
`define SPCP_MDB_PORTS 64
`endif

// file: include/spcp_pkg.sv
// Types of the status poller cable port
package spcp_pkg;
   typedef enum logic [4:0] {
      SPCP_IDLE = 5'h01,
      SPCP_FLAGS = 5'h02,
      SPCP_MSG = 5'h04,
      SPCP_PROC = 5'h08,
      SPCP_HOLD = 5'h10
   } spcp_state_type;
   typedef enum logic [1:0] {
      SPCP_PH_LOAD = 2'h0,
      SPCP_PH_INITPOLL = 2'h1,
      SPCP_PH_RUN = 2'h2
   } spcp_mode_type;
endpackage : spcp_pkg

// file: rtl/spcp_poller.sv
// Status poller with byte-serial cable port
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "spcp_map.svh"
module spcp_poller #(
   parameter int USERS = 256,
   parameter int BYTE_CYC = `SPCP_BYTE_CYC,
   parameter int FLAG_CYC = 4
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic [`SPCP_ADDR_W-1:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [15:0] reg_rdata_o,
   output logic cable_tx_o,
   output logic [7:0] cable_tx_data_o,
   output logic cable_flag_pulse_o,
   input wire logic cable_rx_valid_i,
   input wire logic [7:0] cable_rx_data_i,
   input wire logic service_request_i,
   input wire logic [15:0] service_user_i,
   input wire logic controller_irq_req_i,
   output logic controller_irq_ack_o,
   output logic note_valid_o
);
   localparam int UW = $clog2(USERS);
   localparam int CW = $clog2(BYTE_CYC + 1);

   // ************************************************************
   // Status table
   // ************************************************************
   // Plain array so synthesis can map it to RAM; kept outside the struct
   logic [15:0] table_mem [USERS];

   typedef struct packed {
      spcp_pkg::spcp_state_type st;
      spcp_pkg::spcp_mode_type mode;
      logic go;
      logic [UW-1:0] wr_ptr;
      logic [UW-1:0] last_user;
      logic [UW-1:0] poll_ptr;
      logic [15:0] cur_user;
      logic [15:0] prev_user;
      logic prev_valid;
      logic [CW-1:0] cnt;
      logic [8:0] pulses;
      logic [2:0] tx_idx;
      logic [2:0] rx_cnt;
      logic [7:0] tx_byte;
      logic tx_req;
      logic tx_loaded;
      logic [7:0] rx_byte;
      logic rx_rdy;
      logic [31:0] resp;
      logic [15:0] srq_user;
      logic srq_pend;
      logic irq_taken;
      logic [15:0] note_user;
      logic [15:0] note_stat;
      logic note;
      logic init_done;
      logic [15:0] rdata;
      logic [7:0] tx_out;
      logic tx_strobe;
      logic flag_out;
      logic ack;
   } spcp_core_type;

   spcp_core_type r;
   spcp_core_type next_r;
   logic tbl_we;
   logic [UW-1:0] tbl_wa;
   logic [15:0] tbl_wd;

   // Next table entry after p, wrapping to entry one after the last table entry
   function automatic logic [UW-1:0] spcp_step(input logic [UW-1:0] p, input logic [UW-1:0] last);
      spcp_step = (p >= last) ? UW'(1) : UW'(p + UW'(1));
   endfunction : spcp_step

   always_comb begin
      next_r = r;
      tbl_we = 1'b0;
      tbl_wa = '0;
      tbl_wd = '0;
      next_r.tx_strobe = 1'b0;
      next_r.flag_out = 1'b0;
      next_r.ack = 1'b0;
      next_r.rdata = 16'h0000;

      // ************************************************************
      // Register port
      // ************************************************************
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            `SPCP_OFF_CTRL: begin
               next_r.go = reg_wdata_i[`SPCP_CTRL_GO];
               if (reg_wdata_i[`SPCP_CTRL_INIT]) begin
                  next_r.mode = spcp_pkg::SPCP_PH_LOAD;
                  next_r.wr_ptr = UW'(1);
                  next_r.init_done = 1'b0;
                  next_r.prev_valid = 1'b0;
                  next_r.srq_pend = 1'b0;
               end
            end
            `SPCP_OFF_TX_BYTE: begin
               next_r.tx_byte = reg_wdata_i[7:0];
               next_r.tx_req = 1'b0;
               next_r.tx_loaded = 1'b1;
               next_r.irq_taken = 1'b0;
            end
            `SPCP_OFF_TBL_DATA: begin
               if (r.mode == spcp_pkg::SPCP_PH_LOAD) begin
                  tbl_we = 1'b1;
                  tbl_wa = r.wr_ptr;
                  tbl_wd = reg_wdata_i;
                  if (reg_wdata_i == `SPCP_TERM_WORD) begin
                     next_r.last_user = UW'(r.wr_ptr - UW'(1));
                     next_r.mode = spcp_pkg::SPCP_PH_INITPOLL;
                     next_r.poll_ptr = UW'(1);
                  end else begin
                     next_r.wr_ptr = UW'(r.wr_ptr + UW'(1));
                  end
               end
            end
            default: begin
            end
         endcase
      end
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            `SPCP_OFF_CTRL: next_r.rdata = {14'h0000, r.mode != spcp_pkg::SPCP_PH_RUN, r.go};
            `SPCP_OFF_STATUS: next_r.rdata = {11'h000, r.note, r.init_done, r.st == spcp_pkg::SPCP_MSG,
                                              r.rx_rdy, r.tx_req};
            `SPCP_OFF_RX_BYTE: begin
               next_r.rdata = {8'h00, r.rx_byte};
               next_r.rx_rdy = 1'b0;
               next_r.irq_taken = 1'b0;
            end
            `SPCP_OFF_TBL_ADDR: next_r.rdata = 16'(r.last_user);
            `SPCP_OFF_NOTE_USER: next_r.rdata = r.note_user;
            `SPCP_OFF_NOTE_STAT: begin
               next_r.rdata = r.note_stat;
               next_r.note = 1'b0;
            end
            `SPCP_OFF_SRQ: next_r.rdata = r.srq_user;
            default: next_r.rdata = 16'h0000;
         endcase
      end

      // Service requests honoured only once initialization finished
      if (service_request_i && r.init_done && !r.srq_pend) begin
         next_r.srq_pend = 1'b1;
         next_r.srq_user = service_user_i;
      end

      // One controller interrupt per cable byte access in the phase
      if (controller_irq_req_i && (r.st != spcp_pkg::SPCP_MSG || !r.irq_taken)) begin
         next_r.ack = 1'b1;
         if (r.st == spcp_pkg::SPCP_MSG) begin
            next_r.irq_taken = 1'b1;
         end
      end

      // ************************************************************
      // Frame sequencer
      // ************************************************************
      unique case (r.st)
         spcp_pkg::SPCP_IDLE: begin
            if (r.go && r.mode != spcp_pkg::SPCP_PH_LOAD) begin
               next_r.st = spcp_pkg::SPCP_FLAGS;
               next_r.pulses = 9'h000;
               next_r.cnt = '0;
            end
         end
         spcp_pkg::SPCP_FLAGS: begin
            next_r.cnt = CW'(r.cnt + CW'(1));
            if (r.cnt == CW'(FLAG_CYC - 1)) begin
               next_r.cnt = '0;
               next_r.flag_out = 1'b1;
               next_r.pulses = 9'(r.pulses + 9'h001);
               if (r.pulses == 9'(`SPCP_FLAG_PULSES - 1)) begin
                  next_r.st = spcp_pkg::SPCP_MSG;
                  next_r.tx_idx = 3'h0;
                  next_r.rx_cnt = 3'h0;
                  next_r.tx_req = 1'b1;
                  next_r.tx_loaded = 1'b0;
                  next_r.irq_taken = 1'b0;
               end
            end
         end
         spcp_pkg::SPCP_MSG: begin
            next_r.cnt = CW'(r.cnt + CW'(1));
            if (cable_rx_valid_i && r.prev_valid && r.rx_cnt < 3'(`SPCP_RX_BYTES)) begin
               next_r.rx_byte = cable_rx_data_i;
               next_r.rx_rdy = 1'b1;
               next_r.resp = {r.resp[23:0], cable_rx_data_i};
               next_r.rx_cnt = 3'(r.rx_cnt + 3'h1);
            end
            if (r.cnt == CW'(BYTE_CYC - 1)) begin
               next_r.cnt = '0;
               // Unloaded byte slot goes out as zero so the frame still completes
               next_r.tx_out = r.tx_loaded ? r.tx_byte : 8'h00;
               next_r.tx_strobe = 1'b1;
               next_r.tx_loaded = 1'b0;
               next_r.tx_idx = 3'(r.tx_idx + 3'h1);
               if (r.tx_idx == 3'(`SPCP_TX_BYTES - 1)) begin
                  next_r.tx_req = 1'b0;
                  next_r.st = spcp_pkg::SPCP_PROC;
               end else begin
                  next_r.tx_req = 1'b1;
               end
            end
         end
         spcp_pkg::SPCP_PROC: begin
            // Response attributed to the poll one block back
            if (r.prev_valid && r.prev_user != 16'h0000) begin
               if (r.rx_cnt != 3'(`SPCP_RX_BYTES)) begin
                  tbl_we = 1'b1;
                  tbl_wa = UW'(r.prev_user);
                  tbl_wd = {table_mem[UW'(r.prev_user)][15:8],
                            (r.prev_user == 16'h0001) ? 8'h01 : `SPCP_OOS_ALL};
                  next_r.note_user = r.prev_user;
                  next_r.note_stat = tbl_wd;
                  next_r.note = 1'b1;
               end else if (r.resp[31:16] != 16'h0000 ||
                            r.resp[7:0] != table_mem[UW'(r.prev_user)][7:0]) begin
                  tbl_we = 1'b1;
                  tbl_wa = UW'(r.prev_user);
                  // Buffer reply passes to the controller unchanged; table keeps only bit 0
                  tbl_wd = (r.prev_user == 16'h0001) ? {15'h0000, r.resp[0]} :
                           {table_mem[UW'(r.prev_user)][15:8], r.resp[7:0]};
                  next_r.note_user = r.prev_user;
                  next_r.note_stat = r.resp[15:0];
                  next_r.note = 1'b1;
               end
            end
            next_r.prev_user = r.cur_user;
            next_r.prev_valid = 1'b1;
            next_r.resp = 32'h0000_0000;
            // Choose the next poll target
            if (r.mode == spcp_pkg::SPCP_PH_INITPOLL) begin
               if (r.poll_ptr == '0) begin
                  next_r.cur_user = 16'h0000;
                  if (r.cur_user == 16'h0000) begin
                     next_r.mode = spcp_pkg::SPCP_PH_RUN;
                     next_r.init_done = 1'b1;
                     // Entry zero is never loaded, so routine polls must restart at user one
                     next_r.poll_ptr = UW'(1);
                  end
               end else begin
                  next_r.cur_user = 16'(r.poll_ptr);
                  next_r.poll_ptr = (r.poll_ptr >= r.last_user) ? '0 : UW'(r.poll_ptr + UW'(1));
               end
            end else if (r.srq_pend) begin
               next_r.cur_user = r.srq_user;
               next_r.srq_pend = 1'b0;
            end else if (r.last_user != '0 && !table_mem[r.poll_ptr][`SPCP_UNASSIGNED_BIT]) begin
               next_r.cur_user = 16'(r.poll_ptr);
               next_r.poll_ptr = spcp_step(r.poll_ptr, r.last_user);
            end else begin
               next_r.cur_user = 16'h0000;
               next_r.poll_ptr = spcp_step(r.poll_ptr, r.last_user);
            end
            // Unassigned entries during initialization get a null poll
            if (r.mode == spcp_pkg::SPCP_PH_INITPOLL && r.poll_ptr != '0 &&
                table_mem[r.poll_ptr][`SPCP_UNASSIGNED_BIT]) begin
               next_r.cur_user = 16'h0000;
            end
            next_r.st = spcp_pkg::SPCP_HOLD;
         end
         spcp_pkg::SPCP_HOLD: begin
            next_r.st = r.go ? spcp_pkg::SPCP_FLAGS : spcp_pkg::SPCP_IDLE;
            next_r.pulses = 9'h000;
            next_r.cnt = '0;
         end
         default: next_r.st = spcp_pkg::SPCP_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         r <= '{st: spcp_pkg::SPCP_IDLE, mode: spcp_pkg::SPCP_PH_LOAD, wr_ptr: UW'(1), poll_ptr: UW'(1),
                default: '0};
      end else begin
         r <= next_r;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (tbl_we) begin
         table_mem[tbl_wa] <= tbl_wd;
      end
   end

   assign reg_rdata_o = r.rdata;
   assign cable_tx_o = r.tx_strobe;
   assign cable_tx_data_o = r.tx_out;
   assign cable_flag_pulse_o = r.flag_out;
   assign controller_irq_ack_o = r.ack;
   assign note_valid_o = r.note;
endmodule : spcp_poller

// file: verif/spcp_poller_properties.sv
// Concurrent checks on the ports of the status poller cable port
`timescale 1ns/1ps
`include "spcp_map.svh"
module spcp_poller_properties (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic [`SPCP_ADDR_W-1:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [15:0] reg_rdata_o,
   input wire logic cable_tx_o,
   input wire logic cable_flag_pulse_o,
   input wire logic cable_rx_valid_i,
   input wire logic controller_irq_req_i,
   input wire logic controller_irq_ack_o,
   input wire logic note_valid_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   // ***********************************
   // Message phase tracking
   // ***********************************
   // Phase is rebuilt from flag pulses and cable bytes, as only ports are visible here
   logic [8:0] flag_cnt;
   logic [2:0] tx_cnt;
   logic msg_now;
   logic msg_prev;
   logic irq_granted;
   logic cable_access;
   assign msg_now = (flag_cnt == 9'(`SPCP_FLAG_PULSES - 1) && cable_flag_pulse_o) ||
                    (flag_cnt == 9'(`SPCP_FLAG_PULSES) && !(cable_tx_o && tx_cnt == 3'(`SPCP_TX_BYTES - 1)));
   assign cable_access = (reg_wr_i && reg_addr_i == `SPCP_OFF_TX_BYTE) ||
                         (reg_rd_i && reg_addr_i == `SPCP_OFF_RX_BYTE);
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         flag_cnt <= 9'h000;
         tx_cnt <= 3'h0;
         msg_prev <= 1'b0;
         irq_granted <= 1'b0;
      end else begin
         msg_prev <= msg_now;
         if (cable_tx_o) begin
            tx_cnt <= (tx_cnt == 3'(`SPCP_TX_BYTES - 1)) ? 3'h0 : 3'(tx_cnt + 3'h1);
         end
         if (cable_tx_o && tx_cnt == 3'(`SPCP_TX_BYTES - 1)) begin
            flag_cnt <= 9'h000;
         end else if (cable_flag_pulse_o) begin
            flag_cnt <= 9'(flag_cnt + 9'h001);
         end
         // A cable access reopens the interrupt window; leaving the phase resets it
         if (cable_access || !msg_prev) begin
            irq_granted <= 1'b0;
         end else if (controller_irq_ack_o) begin
            irq_granted <= 1'b1;
         end
      end
   end
   // ***********************************
   // Assertions
   // ***********************************
   AST_RDATA_IDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0) else $error("read data without read");
   AST_TX_PULSE: assert property (cable_tx_o |=> !cable_tx_o[*8]) else $error("cable bytes too close");
   AST_FLAG_GAP: assert property (cable_flag_pulse_o |=> !cable_flag_pulse_o[*3]) else $error("flag spacing");
   AST_FRAME_SPLIT: assert property (!(cable_tx_o && cable_flag_pulse_o)) else $error("byte inside flags");
   AST_TXREQ_CLR: assert property ((reg_wr_i && reg_addr_i == `SPCP_OFF_TX_BYTE) ##2
      (reg_rd_i && reg_addr_i == `SPCP_OFF_STATUS) |=> !reg_rdata_o[`SPCP_ST_TXREQ]) else $error("request not cleared");
   AST_RXRDY_CLR: assert property ((reg_rd_i && reg_addr_i == `SPCP_OFF_RX_BYTE && !cable_rx_valid_i)
      ##1 !cable_rx_valid_i ##1 (reg_rd_i && reg_addr_i == `SPCP_OFF_STATUS)
      |=> !reg_rdata_o[`SPCP_ST_RXRDY]) else $error("ready not cleared");
   AST_ACK_CAUSE: assert property (controller_irq_ack_o |-> $past(controller_irq_req_i)) else $error("ack without req");
   AST_ACK_ONCE: assert property (controller_irq_ack_o && msg_prev |-> !irq_granted) else $error("second ack");
   AST_NOTE_CLR: assert property ((reg_rd_i && reg_addr_i == `SPCP_OFF_NOTE_STAT) |=> !note_valid_o)
      else $error("note not cleared");
   // Main scenarios reached
   COV_TX: cover property (cable_tx_o);
   COV_NOTE: cover property ($rose(note_valid_o));
   COV_ACK: cover property (controller_irq_ack_o);
endmodule : spcp_poller_properties

// file: verif/spcp_keypad_model.sv
// Keypad unit on the cable: answers each addressed poll one message block later
`timescale 1ns/1ps
module spcp_keypad_model (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic cable_tx_i,
   input wire logic [7:0] cable_tx_data_i,
   input wire logic answer_i,
   input wire logic [31:0] resp_i,
   output logic rx_valid_o,
   output logic [7:0] rx_data_o
);
   logic [2:0] nbyte;
   logic [13:0] addr;
   logic [2:0] nresp;
   logic [3:0] dly;
   // Idle line inverts every bit each cycle, alternating with the last byte, so a stale read never matches
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         nbyte <= 3'h0; addr <= 14'h0; nresp <= 3'h4; dly <= 4'h0;
         rx_valid_o <= 1'b0; rx_data_o <= 8'h00;
      end else begin
         rx_valid_o <= 1'b0;
         if (!rx_valid_o) rx_data_o <= ~rx_data_o;
         if (dly != 4'h0) begin
            dly <= dly - 4'h1;
            if (dly == 4'h1) begin
               rx_valid_o <= 1'b1;
               rx_data_o <= resp_i[31 - 8 * nresp -: 8];
               nresp <= nresp + 3'h1;
            end
         end
         if (cable_tx_i) begin
            nbyte <= (nbyte == 3'h5) ? 3'h0 : nbyte + 3'h1;
            if (nbyte == 3'h0) addr[13:8] <= cable_tx_data_i[5:0];
            if (nbyte == 3'h1) addr[7:0] <= cable_tx_data_i;
            if (nbyte == 3'h5) begin
               // Response belongs to the next block; user zero gets none
               nresp <= (answer_i && addr != 14'h0) ? 3'h0 : 3'h4;
            end
            if (nresp < 3'h4 && nbyte != 3'h5) dly <= 4'ha;
         end
      end
   end
endmodule : spcp_keypad_model

// file: verif/spcp_poller_bench.sv
// Self-checking bench of the status poller cable port
`timescale 1ns/1ps
`include "spcp_map.svh"
module spcp_poller_bench;
   logic sys_clk_i, sys_rst_i, reg_wr_i, reg_rd_i, tx, rxv, srq, irq, ack, note, flag, answer;
   logic [3:0] reg_addr_i;
   logic [15:0] reg_wdata_i, reg_rdata_o, r;
   logic [7:0] txd, rxd, b;
   logic [31:0] seed, resp;
   int n_fail, checks, nrx, k, f;
   logic [7:0] exp_q[$];
   logic [15:0] tbl_words [4] = '{16'h0000, 16'h0000, 16'h8000, `SPCP_TERM_WORD};
   spcp_poller #(.USERS(8), .BYTE_CYC(20), .FLAG_CYC(4)) i_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .cable_tx_o(tx), .cable_tx_data_o(txd), .cable_flag_pulse_o(flag),
      .cable_rx_valid_i(rxv), .cable_rx_data_i(rxd), .service_request_i(srq), .service_user_i(16'h0002),
      .controller_irq_req_i(irq), .controller_irq_ack_o(ack), .note_valid_o(note));
   spcp_keypad_model i_keypad (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .cable_tx_i(tx),
      .cable_tx_data_i(txd), .answer_i(answer), .resp_i(resp), .rx_valid_o(rxv), .rx_data_o(rxd));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   // Poll target per frame: null first, init polls 1 and 2, null for unassigned 3 and to close init,
   // routine 1 and 2, null for unassigned 3, then user 2 after its service request
   function automatic logic [7:0] poll_target(input int frame);
      case (frame)
         1, 5: poll_target = 8'h01;
         2, 6, 8: poll_target = 8'h02;
         default: poll_target = 8'h00;
      endcase
   endfunction : poll_target
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expv);
      checks++;
      if (seen !== expv) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, expv, seen);
      end
   endtask : check
   task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk_i);
      reg_addr_i <= a; reg_wdata_i <= d; reg_wr_i <= w; reg_rd_i <= !w;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0; reg_rd_i <= 1'b0;
      #1 r = reg_rdata_o;
   endtask : acc
   task automatic end_of_test();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_of_test
   // ***********************************
   // Cable byte monitor
   // ***********************************
   always @(posedge sys_clk_i) if (tx) check("cable byte", {8'h0, txd}, {8'h0, exp_q.pop_front()});
   initial begin
      sys_clk_i = 1'b0;
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      sys_rst_i = 1'b1; reg_wr_i = 1'b0; reg_rd_i = 1'b0; reg_addr_i = 4'h0; reg_wdata_i = 16'h0;
      srq = 1'b0; irq = 1'b0; answer = 1'b1; seed = 32'h2f29; resp = 32'h0; n_fail = 0; checks = 0;
      repeat (5) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      seed = lfsr(seed);
      resp = seed;
      acc(1'b1, `SPCP_OFF_CTRL, 16'h0002);
      // Users 1 and 2 assigned and in service, user 3 unassigned, then the end word
      foreach (tbl_words[i]) acc(1'b1, `SPCP_OFF_TBL_DATA, tbl_words[i]);
      acc(1'b1, `SPCP_OFF_CTRL, 16'h0001);
      for (f = 0; f < 9; f++) begin
         nrx = 0;
         answer <= (f != 6);
         irq <= (f == 3);
         srq <= (f == 1 || f == 7);
         for (int n = 0; n < 6; n++) begin
            for (k = 0; k < 1500; k++) begin
               acc(1'b0, `SPCP_OFF_STATUS, 16'h0);
               if (r[`SPCP_ST_TXREQ]) break;
               if (r[`SPCP_ST_RXRDY]) begin
                  acc(1'b0, `SPCP_OFF_RX_BYTE, 16'h0);
                  check("rx byte", r, {8'h0, resp[31 - 8 * (nrx % 4) -: 8]});
                  nrx++;
               end
            end
            if (k == 1500) begin
               n_fail++;
               end_of_test();
            end
            if (n == 0) check("phase", {15'h0, r[`SPCP_ST_PHASE]}, 16'h1);
            seed = lfsr(seed);
            b = (n == 0) ? 8'h00 : (n == 1) ? poll_target(f) : seed[7:0];
            exp_q.push_back(b);
            acc(1'b1, `SPCP_OFF_TX_BYTE, {8'h0, b});
            acc(1'b0, `SPCP_OFF_STATUS, 16'h0);
            if (r[`SPCP_ST_RXRDY]) begin
               acc(1'b0, `SPCP_OFF_RX_BYTE, 16'h0);
               check("rx byte", r, {8'h0, resp[31 - 8 * (nrx % 4) -: 8]});
               nrx++;
            end
         end
         repeat (40) @(posedge sys_clk_i);
         check("rx count", 16'(nrx), (f >= 1 && poll_target(f - 1) != 8'h00 && f != 7) ? 16'h4 : 16'h0);
         if (f == 1 || f == 8) begin
            acc(1'b0, `SPCP_OFF_SRQ, 16'h0);
            check("srq user", r, (f == 1) ? 16'h0000 : 16'h0002);
         end
         // Silent station: all its equipment reported out of service
         if (f == 7) begin
            check("note", {15'h0, note}, 16'h1);
            acc(1'b0, `SPCP_OFF_NOTE_USER, 16'h0);
            check("note user", r, 16'h0002);
            acc(1'b0, `SPCP_OFF_NOTE_STAT, 16'h0);
            check("note status", {8'h0, r[7:0]}, {8'h0, `SPCP_OOS_ALL});
         end else if (note) acc(1'b0, `SPCP_OFF_NOTE_STAT, 16'h0);
      end
      acc(1'b0, 4'hf, 16'h0);
      check("unmapped read", r, 16'h0);
      end_of_test();
   end
endmodule : spcp_poller_bench
bind spcp_poller spcp_poller_properties i_props (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
   .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .cable_tx_o(cable_tx_o), .cable_flag_pulse_o(cable_flag_pulse_o), .cable_rx_valid_i(cable_rx_valid_i),
   .controller_irq_req_i(controller_irq_req_i), .controller_irq_ack_o(controller_irq_ack_o),
   .note_valid_o(note_valid_o));
